/* rtl/i2c_cfg_pkg.sv */
`default_nettype none
package i2c_cfg_pkg;
  localparam int DATA_W        = 8;
  localparam int DEV_ADDR_W    = 7;
  localparam int REG_DEPTH     = 256;
  localparam int FIFO_DEPTH    = 2;
  localparam int TIMER_W       = 8;

  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2A;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int MAX_RATE_KBPS  = 400;
  localparam int SCL_PERIOD_NS  = 1000000 / MAX_RATE_KBPS;
  localparam int T_LOW_NS       = 1300;
  localparam int T_HIGH_NS      = 600;
  localparam int T_HD_STA_NS    = 600;
  localparam int T_SU_STO_NS    = 600;
  localparam int T_BUF_NS       = 1300;
  localparam int T_HD_DAT_NS    = 100;

  function automatic int cycles_min(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : cycles_min

  localparam int PERIOD_CYC  = cycles_min(SCL_PERIOD_NS);
  localparam int LOW_CYC     = cycles_min(T_LOW_NS);
  localparam int HIGH_MIN    = cycles_min(T_HIGH_NS);
  localparam int HIGH_CYC    = (PERIOD_CYC - LOW_CYC > HIGH_MIN) ? PERIOD_CYC - LOW_CYC : HIGH_MIN;
  localparam int HD_STA_CYC  = cycles_min(T_HD_STA_NS);
  localparam int SU_STO_CYC  = cycles_min(T_SU_STO_NS);
  localparam int BUF_CYC     = cycles_min(T_BUF_NS);
  localparam int HD_DAT_CYC  = cycles_min(T_HD_DAT_NS);

  localparam logic [TIMER_W-1:0] LOW_TICKS    = TIMER_W'(LOW_CYC - 1);
  localparam logic [TIMER_W-1:0] HIGH_TICKS   = TIMER_W'(HIGH_CYC - 1);
  localparam logic [TIMER_W-1:0] HD_STA_TICKS = TIMER_W'(HD_STA_CYC - 1);
  localparam logic [TIMER_W-1:0] SU_STO_TICKS = TIMER_W'(SU_STO_CYC - 1);
  localparam logic [TIMER_W-1:0] BUF_TICKS    = TIMER_W'(BUF_CYC - 1);
  localparam logic [TIMER_W-1:0] CHANGE_TICK  = TIMER_W'(LOW_CYC - 1 - HD_DAT_CYC);

  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} op_t;

  typedef struct packed {
    op_t               op;
    logic              nack;
    logic [DATA_W-1:0] data;
  } cmd_t;
endpackage : i2c_cfg_pkg
`default_nettype wire

/* rtl/i2c_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic serial_clock_line;
  logic serial_data_line;

  // Open-drain wires with pull-up: low whenever any enabled driver drives low
  assign serial_clock_line = !(scl_oe && !scl_o);
  assign serial_data_line  = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (output scl_o, scl_oe, m_sda_o, m_sda_oe, input serial_clock_line, serial_data_line);
  modport slave  (output s_sda_o, s_sda_oe, input serial_clock_line, serial_data_line);
endinterface : i2c_link_if
`default_nettype wire

/* rtl/cfg_i2c_slave.sv */
// Function
// - Host enables serial port before any transfer
// - Read and write supported up to 400 kbit/s
// - Write: start, address, R/W, ack, register, ack, data
// - Later data bytes go to successive addresses
// - Data stable while clock high
// - Start is data falling, clock high; address follows
// - Stop is data rising, clock high; ends frame
// - Acknowledge each written byte on ninth clock
// - Master acknowledges each byte it reads except the last, which it does not acknowledge
`timescale 1ns/1ps
`default_nettype none
module cfg_i2c_slave
  import i2c_cfg_pkg::*;
#(
  parameter logic [DEV_ADDR_W-1:0] OWN_ADDR = DEFAULT_DEV_ADDR
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Two-wire link
  i2c_link_if.slave              link,
  // Configuration
  input  wire logic              serial_enable,
  // Register write notification
  output logic                   wr_stb,
  output logic [DATA_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data,
  // Local read port
  input  wire logic [DATA_W-1:0] cfg_rd_addr,
  output logic [DATA_W-1:0]      cfg_rd_data,
  // Status
  output logic                   frame_active
);

  typedef enum {PH_IDLE, PH_DEV, PH_REG, PH_WR, PH_RD} phase_t;

  logic [DATA_W-1:0] mem_q [REG_DEPTH];

  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_q_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_q_r;

  phase_t            phase_r;
  phase_t            phase_nxt;
  logic [3:0]        bit_r;
  logic [3:0]        bit_nxt;
  logic [6:0]        shift_r;
  logic [6:0]        shift_nxt;
  logic [DATA_W-1:0] addr_r;
  logic [DATA_W-1:0] addr_nxt;
  logic              rw_r;
  logic              rw_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic              active_r;
  logic              active_nxt;
  logic              wr_stb_r;
  logic              wr_stb_nxt;
  logic [DATA_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_addr_nxt;
  logic [DATA_W-1:0] wr_data_r;
  logic [DATA_W-1:0] wr_data_nxt;
  logic [DATA_W-1:0] cfg_rd_data_r;

  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic [DATA_W-1:0] rx_byte;
  logic [DATA_W-1:0] tx_byte;
  logic [2:0]        tx_idx;

  // Both lines pass the same three stages, so their relative timing is kept
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_q_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_q_r  <= 1'b1;
    end else begin
      scl_s1_r <= link.serial_clock_line;
      scl_s2_r <= scl_s1_r;
      scl_q_r  <= scl_s2_r;
      sda_s1_r <= link.serial_data_line;
      sda_s2_r <= sda_s1_r;
      sda_q_r  <= sda_s2_r;
    end
  end

  assign scl_rise  = scl_s2_r && !scl_q_r;
  assign scl_fall  = !scl_s2_r && scl_q_r;
  // Data edges with clock high in both samples are frame markers, never data
  assign start_det = scl_s2_r && scl_q_r && sda_q_r && !sda_s2_r;
  assign stop_det  = scl_s2_r && scl_q_r && !sda_q_r && sda_s2_r;
  assign rx_byte   = {shift_r, sda_s2_r};
  assign tx_byte   = mem_q[addr_r];
  assign tx_idx    = 3'(LAST_DATA_BIT - bit_r);

  always_comb begin
    phase_nxt   = phase_r;
    bit_nxt     = bit_r;
    shift_nxt   = shift_r;
    addr_nxt    = addr_r;
    rw_nxt      = rw_r;
    oe_nxt      = oe_r;
    active_nxt  = active_r;
    wr_stb_nxt  = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    if (start_det) begin
      // A disabled port ignores the frame's bytes; frame_active still marks the frame
      phase_nxt  = serial_enable ? PH_DEV : PH_IDLE;
      bit_nxt    = 4'h0;
      oe_nxt     = 1'b0;
      active_nxt = 1'b1;
    end else if (stop_det) begin
      phase_nxt  = PH_IDLE;
      oe_nxt     = 1'b0;
      active_nxt = 1'b0;
    end else if (phase_r != PH_IDLE) begin
      if (scl_rise) begin
        // Bits are taken on the rising clock only
        bit_nxt = (bit_r == ACK_SLOT) ? 4'h0 : bit_r + 4'h1;
        if (bit_r != ACK_SLOT) begin
          shift_nxt = rx_byte[6:0];
        end
        if (bit_r == LAST_DATA_BIT) begin
          unique case (phase_r)
            PH_DEV: begin
              if (rx_byte[7:1] != OWN_ADDR) begin
                phase_nxt = PH_IDLE;
              end else begin
                rw_nxt = rx_byte[0];
              end
            end
            PH_REG: addr_nxt = rx_byte;
            PH_WR: begin
              wr_stb_nxt  = 1'b1;
              wr_addr_nxt = addr_r;
              wr_data_nxt = rx_byte;
              addr_nxt    = addr_r + 8'h01;
            end
            PH_RD, PH_IDLE: ;
          endcase
        end
        if (bit_r == ACK_SLOT) begin
          unique case (phase_r)
            PH_DEV: phase_nxt = rw_r ? PH_RD : PH_REG;
            PH_REG: phase_nxt = PH_WR;
            PH_RD: begin
              // A not-acknowledged byte ends the read; wait for stop
              if (sda_s2_r) begin
                phase_nxt = PH_IDLE;
              end else begin
                addr_nxt = addr_r + 8'h01;
              end
            end
            PH_WR, PH_IDLE: ;
          endcase
        end
      end
      if (scl_fall) begin
        // The line is moved only while the clock is low
        if (bit_r == ACK_SLOT) begin
          oe_nxt = (phase_r != PH_RD);
        end else begin
          oe_nxt = (phase_r == PH_RD) && !tx_byte[tx_idx];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r   <= PH_IDLE;
      bit_r     <= 4'h0;
      shift_r   <= 7'h00;
      addr_r    <= 8'h00;
      rw_r      <= 1'b0;
      oe_r      <= 1'b0;
      active_r  <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      phase_r   <= phase_nxt;
      bit_r     <= bit_nxt;
      shift_r   <= shift_nxt;
      addr_r    <= addr_nxt;
      rw_r      <= rw_nxt;
      oe_r      <= oe_nxt;
      active_r  <= active_nxt;
      wr_stb_r  <= wr_stb_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (wr_stb_nxt) begin
      mem_q[addr_r] <= wr_data_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_rd_data_r <= 8'h00;
    end else begin
      cfg_rd_data_r <= mem_q[cfg_rd_addr];
    end
  end

  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = oe_r;
  assign wr_stb        = wr_stb_r;
  assign wr_addr       = wr_addr_r;
  assign wr_data       = wr_data_r;
  assign cfg_rd_data   = cfg_rd_data_r;
  assign frame_active  = active_r;

endmodule : cfg_i2c_slave
`default_nettype wire

/* rtl/cfg_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_i2c_master
  import i2c_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Two-wire link
  i2c_link_if.master             link,
  // Command stream
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire op_t               cmd_op,
  input  wire logic              cmd_nack,
  input  wire logic [DATA_W-1:0] cmd_data,
  // Byte results and busy status
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_nack,
  output logic                   busy
);

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);

  typedef enum {M_IDLE, M_HOLD, M_RS_LOW, M_RS_HIGH, M_START, M_BIT_LOW, M_BIT_HIGH,
                M_P_LOW, M_P_HIGH, M_P_FREE} mstate_t;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : ptr_inc

  cmd_t fifo_mem [FIFO_DEPTH];

  logic [PTR_W-1:0]   wr_ptr_r;
  logic [PTR_W-1:0]   rd_ptr_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic               ready_r;
  logic               push;
  logic               pop;
  cmd_t               head;

  mstate_t            state_r;
  mstate_t            state_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic               scl_low_r;
  logic               scl_low_nxt;
  logic               sda_low_r;
  logic               sda_low_nxt;
  logic [3:0]         bit_r;
  logic [3:0]         bit_nxt;
  logic [DATA_W-1:0]  shift_r;
  logic [DATA_W-1:0]  shift_nxt;
  logic               read_r;
  logic               read_nxt;
  logic               nack_r;
  logic               nack_nxt;
  logic               rsp_valid_r;
  logic               rsp_valid_nxt;
  logic [DATA_W-1:0]  rsp_data_r;
  logic [DATA_W-1:0]  rsp_data_nxt;
  logic               rsp_nack_r;
  logic               rsp_nack_nxt;
  logic               busy_r;
  logic               sda_s1_r;
  logic               sda_s2_r;
  logic               tdone;

  assign push = cmd_valid && ready_r;
  assign head = fifo_mem[rd_ptr_r];

  // Inside a frame the engine drains at most one entry per byte, so a slow stream only stalls
  always_ff @(posedge core_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= '{op: cmd_op, nack: cmd_nack, data: cmd_data};
    end
  end

  always_comb begin
    cnt_nxt = cnt_r + CNT_W'(push) - CNT_W'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      ready_r  <= 1'b0;
    end else begin
      wr_ptr_r <= push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
      rd_ptr_r <= pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
      cnt_r    <= cnt_nxt;
      ready_r  <= (cnt_nxt != FULL_CNT);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= link.serial_data_line;
      sda_s2_r <= sda_s1_r;
    end
  end

  assign tdone = (timer_r == '0);

  always_comb begin
    state_nxt     = state_r;
    timer_nxt     = tdone ? timer_r : timer_r - TIMER_W'(1);
    scl_low_nxt   = scl_low_r;
    sda_low_nxt   = sda_low_r;
    bit_nxt       = bit_r;
    shift_nxt     = shift_r;
    read_nxt      = read_r;
    nack_nxt      = nack_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt  = rsp_data_r;
    rsp_nack_nxt  = rsp_nack_r;
    pop           = 1'b0;
    unique case (state_r)
      M_IDLE, M_HOLD: begin
        if (cnt_r != '0) begin
          pop = 1'b1;
          // Data ops outside a frame and a stop on an idle bus are dropped
          unique case (head.op)
            OP_START: begin
              shift_nxt   = head.data;
              read_nxt    = 1'b0;
              sda_low_nxt = (state_r == M_HOLD) ? sda_low_r : 1'b0;
              state_nxt   = (state_r == M_HOLD) ? M_RS_LOW : M_RS_HIGH;
              timer_nxt   = (state_r == M_HOLD) ? LOW_TICKS : HIGH_TICKS;
            end
            OP_WRITE, OP_READ: begin
              if (state_r == M_HOLD) begin
                read_nxt  = (head.op == OP_READ);
                nack_nxt  = head.nack;
                shift_nxt = (head.op == OP_READ) ? 8'hFF : head.data;
                bit_nxt   = 4'h0;
                timer_nxt = LOW_TICKS;
                state_nxt = M_BIT_LOW;
              end
            end
            OP_STOP: begin
              if (state_r == M_HOLD) begin
                timer_nxt = LOW_TICKS;
                state_nxt = M_P_LOW;
              end
            end
          endcase
        end
      end
      M_RS_LOW: begin
        if (timer_r == CHANGE_TICK) begin
          sda_low_nxt = 1'b0;
        end
        if (tdone) begin
          scl_low_nxt = 1'b0;
          timer_nxt   = HIGH_TICKS;
          state_nxt   = M_RS_HIGH;
        end
      end
      M_RS_HIGH: begin
        if (tdone) begin
          sda_low_nxt = 1'b1;
          timer_nxt   = HD_STA_TICKS;
          state_nxt   = M_START;
        end
      end
      M_START: begin
        if (tdone) begin
          scl_low_nxt = 1'b1;
          bit_nxt     = 4'h0;
          timer_nxt   = LOW_TICKS;
          state_nxt   = M_BIT_LOW;
        end
      end
      M_BIT_LOW: begin
        // Data moves a hold time after the falling clock
        if (timer_r == CHANGE_TICK) begin
          sda_low_nxt = (bit_r == ACK_SLOT) ? (read_r && !nack_r) : !shift_r[7];
        end
        if (tdone) begin
          scl_low_nxt = 1'b0;
          timer_nxt   = HIGH_TICKS;
          state_nxt   = M_BIT_HIGH;
        end
      end
      M_BIT_HIGH: begin
        if (tdone) begin
          scl_low_nxt = 1'b1;
          timer_nxt   = LOW_TICKS;
          if (bit_r == ACK_SLOT) begin
            rsp_valid_nxt = 1'b1;
            rsp_data_nxt  = shift_r;
            rsp_nack_nxt  = sda_s2_r;
            state_nxt     = M_HOLD;
          end else begin
            shift_nxt = {shift_r[6:0], sda_s2_r};
            bit_nxt   = bit_r + 4'h1;
            state_nxt = M_BIT_LOW;
          end
        end
      end
      M_P_LOW: begin
        if (timer_r == CHANGE_TICK) begin
          sda_low_nxt = 1'b1;
        end
        if (tdone) begin
          scl_low_nxt = 1'b0;
          timer_nxt   = SU_STO_TICKS;
          state_nxt   = M_P_HIGH;
        end
      end
      M_P_HIGH: begin
        if (tdone) begin
          sda_low_nxt = 1'b0;
          timer_nxt   = BUF_TICKS;
          state_nxt   = M_P_FREE;
        end
      end
      M_P_FREE: begin
        if (tdone) begin
          state_nxt = M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r     <= M_IDLE;
      timer_r     <= '0;
      scl_low_r   <= 1'b0;
      sda_low_r   <= 1'b0;
      bit_r       <= 4'h0;
      shift_r     <= 8'h00;
      read_r      <= 1'b0;
      nack_r      <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 8'h00;
      rsp_nack_r  <= 1'b0;
      busy_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      timer_r     <= timer_nxt;
      scl_low_r   <= scl_low_nxt;
      sda_low_r   <= sda_low_nxt;
      bit_r       <= bit_nxt;
      shift_r     <= shift_nxt;
      read_r      <= read_nxt;
      nack_r      <= nack_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r  <= rsp_data_nxt;
      rsp_nack_r  <= rsp_nack_nxt;
      busy_r      <= (state_nxt != M_IDLE);
    end
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = scl_low_r;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = sda_low_r;
  assign cmd_ready     = ready_r;
  assign rsp_valid     = rsp_valid_r;
  assign rsp_data      = rsp_data_r;
  assign rsp_nack      = rsp_nack_r;
  assign busy          = busy_r;

endmodule : cfg_i2c_master
`default_nettype wire

/* testbench/i2c_link_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_link_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link signals
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic serial_clock_line,
  input wire logic serial_data_line
);
  logic [7:0] low_r, low_nxt, high_r, high_nxt, free_r, free_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic       first_r, first_nxt, rw_r, rw_nxt, scl_q, sda_q;
  logic       start_w, rise_w;

  assign start_w = scl_q && serial_clock_line && sda_q && !serial_data_line;
  assign rise_w  = !scl_q && serial_clock_line;

  // Saturating low, high and free counters, so a long idle bus cannot wrap into a short period
  always_comb begin
    low_nxt   = serial_clock_line ? 8'h00 : (low_r == 8'hFF ? low_r : low_r + 8'h01);
    high_nxt  = !serial_clock_line ? 8'h00 : (high_r == 8'hFF ? high_r : high_r + 8'h01);
    free_nxt  = !(serial_clock_line && serial_data_line) ? 8'h00 : (free_r == 8'hFF ? free_r : free_r + 8'h01);
    bit_nxt   = bit_r;
    first_nxt = first_r;
    rw_nxt    = rw_r;
    if (start_w) begin
      bit_nxt   = 4'h0;
      first_nxt = 1'b1;
    end else if (rise_w) begin
      bit_nxt = (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
      if (first_r && bit_r == 4'h7) rw_nxt = serial_data_line;
      if (bit_r == 4'h8) first_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      {low_r, high_r, free_r, bit_r, first_r, rw_r} <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      {low_r, high_r, free_r, bit_r} <= {low_nxt, high_nxt, free_nxt, bit_nxt};
      {first_r, rw_r, scl_q, sda_q}  <= {first_nxt, rw_nxt, serial_clock_line, serial_data_line};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  od_zero_a: assert property (!scl_o && !m_sda_o && !s_sda_o)
    else $error("link output driven high");
  reset_idle_a: assert property ($fell(rst) |-> !scl_oe && !m_sda_oe && !s_sda_oe)
    else $error("link not released after reset");
  slave_change_a: assert property (!$stable(s_sda_oe) |-> !serial_clock_line && !$past(serial_clock_line))
    else $error("slave moved data with clock high");
  master_change_a: assert property (!$stable(m_sda_oe) && serial_clock_line |-> $past(serial_clock_line, 25))
    else $error("master data edge too soon after clock rise");
  master_hold_a: assert property (!$stable(m_sda_oe) && serial_clock_line |=> serial_clock_line [*8])
    else $error("clock fell right after start or stop");
  low_period_a: assert property (rise_w |-> low_r >= 8'h41)
    else $error("clock low period too short");
  high_period_a: assert property (scl_q && !serial_clock_line |-> high_r >= 8'h1E)
    else $error("clock high period too short");
  bus_free_a: assert property (start_w |-> free_r >= 8'h1E)
    else $error("start without bus free time");
  start_hold_a: assert property (start_w |-> ##[20:40] !serial_clock_line)
    else $error("clock did not fall after start");
  no_overlap_a: assert property (serial_clock_line |-> !(s_sda_oe && m_sda_oe))
    else $error("both ends drive data");
  ack_slot_a: assert property (scl_q && serial_clock_line && s_sda_oe && !rw_r |-> bit_r == 4'h9)
    else $error("slave drove data outside ack slot");
endmodule : i2c_link_asserts
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import i2c_cfg_pkg::*;
;
  logic        core_clk, rst, cmd_valid, cmd_ready, cmd_nack, rsp_valid, rsp_nack, busy;
  logic        serial_enable, wr_stb, frame_active;
  op_t         cmd_op;
  logic [7:0]  cmd_data, rsp_data, wr_addr, wr_data, cfg_rd_addr, cfg_rd_data;
  int          failures, checks_done;
  logic [8:0]  rsp_q[$];
  logic [15:0] wr_q[$];
  localparam logic [7:0] AW = {DEFAULT_DEV_ADDR, 1'b0};
  localparam logic [7:0] AR = {DEFAULT_DEV_ADDR, 1'b1};

  i2c_link_if link ();
  cfg_i2c_master cfg_i2c_master_i (.core_clk, .rst, .link(link), .cmd_valid, .cmd_ready, .cmd_op, .cmd_nack,
                                   .cmd_data, .rsp_valid, .rsp_data, .rsp_nack, .busy);
  cfg_i2c_slave cfg_i2c_slave_i (.core_clk, .rst, .link(link), .serial_enable, .wr_stb, .wr_addr, .wr_data,
                                 .cfg_rd_addr, .cfg_rd_data, .frame_active);
  i2c_link_asserts link_asserts_i (.core_clk, .rst, .scl_o(link.scl_o), .scl_oe(link.scl_oe),
                                   .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o),
                                   .s_sda_oe(link.s_sda_oe), .serial_clock_line(link.serial_clock_line),
                                   .serial_data_line(link.serial_data_line));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Mid-cycle sampling keeps one-cycle pulses clear of the clock edge
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back({rsp_nack, rsp_data});
    if (wr_stb === 1'b1) wr_q.push_back({wr_addr, wr_data});
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_bit

  task automatic step(inout int n);
    @(posedge core_clk);
    #1;
    n++;
    if (n > 6000) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
      print_verdict();
    end
  endtask : step

  // One idle edge first, so valid is never raised in the step that lowered it
  task automatic push(input op_t op, input logic nack, input logic [7:0] data);
    int n;
    n = 0;
    step(n);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_nack  = nack;
    cmd_data  = data;
    while (cmd_ready !== 1'b1) step(n);
    step(n);
    cmd_valid = 1'b0;
  endtask : push

  task automatic get_rsp(input logic nack, input logic [7:0] data);
    int         n;
    logic [8:0] r;
    n = 0;
    while (rsp_q.size() == 0) step(n);
    r = rsp_q.pop_front();
    cmp_bit(nack, r[8]);
    cmp_byte(data, r[7:0]);
  endtask : get_rsp

  task automatic get_wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    cmp_bit(1'b1, wr_q.size() > 0);
    w = (wr_q.size() > 0) ? wr_q.pop_front() : 16'hFFFF;
    cmp_byte(a, w[15:8]);
    cmp_byte(d, w[7:0]);
  endtask : get_wr

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0) step(n);
    cmp_bit(1'b0, frame_active);
    cmp_bit(1'b1, cmd_ready);
  endtask : wait_idle

  initial begin
    {rst, cmd_valid, cmd_nack, serial_enable} = 4'hB;
    {cmd_data, cfg_rd_addr, failures, checks_done} = '0;
    cmd_op = OP_START;
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;

    push(OP_START, 1'b0, AW);
    push(OP_WRITE, 1'b0, 8'hFE);
    push(OP_WRITE, 1'b0, 8'hA5);
    repeat (3) @(posedge core_clk);
    #1;
    cmp_bit(1'b0, cmd_ready);
    push(OP_WRITE, 1'b0, 8'h3C);
    push(OP_WRITE, 1'b0, 8'hFF);
    push(OP_STOP, 1'b0, 8'h00);
    get_rsp(1'b0, AW);
    cmp_bit(1'b1, frame_active);
    get_rsp(1'b0, 8'hFE);
    get_rsp(1'b0, 8'hA5);
    get_rsp(1'b0, 8'h3C);
    get_rsp(1'b0, 8'hFF);
    wait_idle();
    get_wr(8'hFE, 8'hA5);
    get_wr(8'hFF, 8'h3C);
    get_wr(8'h00, 8'hFF);
    cfg_rd_addr = 8'hFF;
    repeat (2) @(posedge core_clk);
    #1;
    cmp_byte(8'h3C, cfg_rd_data);
    $display("test write_burst done");

    // Data and stop with no open frame must leave the bus untouched
    push(OP_WRITE, 1'b0, 8'h77);
    push(OP_STOP, 1'b0, 8'h00);
    repeat (4) @(posedge core_clk);
    #1;
    cmp_bit(1'b0, busy);
    cmp_byte(8'h00, 8'(rsp_q.size()));
    $display("test idle_drop done");

    push(OP_START, 1'b0, AW ^ 8'h02);
    push(OP_WRITE, 1'b0, 8'h55);
    push(OP_STOP, 1'b0, 8'h00);
    get_rsp(1'b1, AW ^ 8'h02);
    get_rsp(1'b1, 8'h55);
    wait_idle();
    cmp_byte(8'h00, 8'(wr_q.size()));
    $display("test foreign_address done");

    serial_enable = 1'b0;
    push(OP_START, 1'b0, AW);
    push(OP_WRITE, 1'b0, 8'h00);
    push(OP_STOP, 1'b0, 8'h00);
    get_rsp(1'b1, AW);
    get_rsp(1'b1, 8'h00);
    wait_idle();
    serial_enable = 1'b1;
    cmp_byte(8'h00, 8'(wr_q.size()));
    $display("test port_disabled done");

    push(OP_START, 1'b0, AW);
    push(OP_WRITE, 1'b0, 8'hFF);
    push(OP_START, 1'b0, AR);
    push(OP_READ, 1'b0, 8'h00);
    push(OP_READ, 1'b1, 8'h00);
    push(OP_STOP, 1'b0, 8'h00);
    get_rsp(1'b0, AW);
    get_rsp(1'b0, 8'hFF);
    get_rsp(1'b0, AR);
    get_rsp(1'b0, 8'h3C);
    get_rsp(1'b1, 8'hFF);
    wait_idle();
    cmp_byte(8'h00, 8'(wr_q.size()));
    $display("test read_back done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
